// ===== pkg/pof_pkg.sv
// constants, types and helpers shared by the pixel output formatter
package pof_pkg;

  // ==========================================================
  // widths
  localparam int PIX_W      = 12;
  localparam int TAP_MAX    = 10;
  localparam int LINE_CNT_W = 14;
  localparam int TAP_CNT_W  = 4;

  // ==========================================================
  // minimum line periods in core clocks, by tap count
  localparam int LINE_CLK_1TAP  = 15200;
  localparam int LINE_CLK_2TAP  = 7625;
  localparam int LINE_CLK_4TAP  = 3810;
  localparam int LINE_CLK_8TAP  = 1910;
  localparam int LINE_CLK_10TAP = 1875;

  // ==========================================================
  // reset values
  localparam logic [LINE_CNT_W-1:0] LINE_CNT_RST = 14'h3fff;
  localparam logic [TAP_CNT_W-1:0]  NTAPS_RST    = 4'h1;

  // ==========================================================
  // modes and states
  typedef enum logic [1:0] {
    OUT_12 = 2'h0,
    OUT_10 = 2'h1,
    OUT_8  = 2'h2
  } out_width_t;

  typedef enum logic [2:0] {
    TAPS_1  = 3'h0,
    TAPS_2  = 3'h1,
    TAPS_4  = 3'h2,
    TAPS_8  = 3'h3,
    TAPS_10 = 3'h4
  } tap_mode_t;

  typedef enum logic [2:0] {
    LS_WAIT = 3'b001,
    LS_GO   = 3'b010,
    LS_RUN  = 3'b100
  } line_state_t;

  typedef struct packed {
    logic line_first;
    logic line_last;
    logic frame_first;
    logic frame_last;
  } grp_flags_t;

  // ==========================================================
  // number of active taps for a tap mode code
  function automatic logic [TAP_CNT_W-1:0] tap_count(input logic [2:0] mode);
    case (mode)
      TAPS_2:  tap_count = 4'h2;
      TAPS_4:  tap_count = 4'h4;
      TAPS_8:  tap_count = 4'h8;
      TAPS_10: tap_count = 4'ha;
      default: tap_count = 4'h1;
    endcase
  endfunction

endpackage

// ===== pkg/pof_xfer_if.sv
// pixel group hand-over between the core domain and the link domain
`timescale 1ns/1ps
interface pof_xfer_if;
  logic                                             req;
  logic                                             ack;
  logic [pof_pkg::TAP_MAX*pof_pkg::PIX_W-1:0]       data;
  pof_pkg::grp_flags_t                              flags;

  modport core (
    output req,
    output data,
    output flags,
    input  ack
  );

  modport link (
    input  req,
    input  data,
    input  flags,
    output ack
  );
endinterface

// ===== rtl/pof_link_tx.sv
// link-clock side: takes pixel groups over a toggle handshake and drives the video link
`timescale 1ns/1ps
module pof_link_tx (
  // link clock and reset
  input  wire logic                                       link_clk,
  input  wire logic                                       sys_rst,
  // hand-over from core domain
  pof_xfer_if.link                                        xfer,
  // video link
  output logic [pof_pkg::TAP_MAX*pof_pkg::PIX_W-1:0]      link_data,
  output logic                                            link_dval,
  output logic                                            link_lval,
  output logic                                            link_fval
);

  typedef struct packed {
    logic                                       rst_s1;
    logic                                       rst_s2;
    logic                                       req_s1;
    logic                                       req_s2;
    logic                                       ack;
    logic [pof_pkg::TAP_MAX*pof_pkg::PIX_W-1:0] data;
    pof_pkg::grp_flags_t                        flags;
    logic                                       dval;
    logic                                       lval;
    logic                                       fval;
  } link_state_t;

  localparam link_state_t LINK_RST = '{rst_s1: 1'b1, rst_s2: 1'b1, default: '0};

  link_state_t r;
  link_state_t next_r;

  // ==========================================================
  // next state
  always_comb begin
    next_r        = r;
    next_r.rst_s1 = 1'b0;
    next_r.rst_s2 = r.rst_s1;
    next_r.req_s1 = xfer.req;
    next_r.req_s2 = r.req_s1;
    next_r.dval   = 1'b0;
    // line and frame close after their last group
    if (r.dval && r.flags.line_last) begin
      next_r.lval = 1'b0;
    end
    if (r.dval && r.flags.frame_last) begin
      next_r.fval = 1'b0;
    end
    // new group: one data-valid cycle, all taps in parallel
    if (r.req_s2 != r.ack) begin
      next_r.ack   = ~r.ack;
      next_r.data  = xfer.data;
      next_r.flags = xfer.flags;
      next_r.dval  = 1'b1;
      next_r.lval  = 1'b1;
      next_r.fval  = r.fval | xfer.flags.frame_first;
    end
    if (r.rst_s2) begin
      next_r        = LINK_RST;
      next_r.rst_s1 = 1'b0;
      next_r.rst_s2 = r.rst_s1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= LINK_RST;
    end else begin
      r <= next_r;
    end
  end

  assign xfer.ack  = r.ack;
  assign link_data = r.data;
  assign link_dval = r.dval;
  assign link_lval = r.lval;
  assign link_fval = r.fval;

endmodule

// ===== rtl/pixel_output_formatter.sv
// pixel output formatter: bit-depth mapping, tap packing and line period control
//
// Summary of operation
// - Internal digitization is chosen as 10 or 12 bits by a configuration input.
// - Output pixel width is chosen as 12, 10 or 8 bits independently of digitization.
// - Narrowing to 8 bits drops low bits with no rounding.
// - 12-bit digitization, 12-bit output: sensor bits 11..0 go straight to output 11..0.
// - 12-bit digitization, 10-bit output: output 9..0 take sensor bits 11..2.
// - 12-bit digitization, 8-bit output: output 7..0 take sensor bits 11..4.
// - 10-bit digitization, 12-bit output: sensor 9..0 go to output 11..2, output 1..0 are zero.
// - 10-bit digitization, 10-bit output: sensor 9..0 go straight to output 9..0.
// - 10-bit digitization, 8-bit output: output 7..0 take sensor bits 9..2.
// - Tap counts of 1, 2, 4, 8 or 10 are supported, pixels leaving in groups of that size, the last group of a line possibly shorter.
// - Sensor readout is slowed to the link by a minimum line period chosen by tap count.
// - Minimum line periods are 15200, 7625, 3810, 1910 and 1875 clocks for 1, 2, 4, 8, 10 taps.
`timescale 1ns/1ps
module pixel_output_formatter #(
  parameter int LINE_CLK_1TAP  = pof_pkg::LINE_CLK_1TAP,
  parameter int LINE_CLK_2TAP  = pof_pkg::LINE_CLK_2TAP,
  parameter int LINE_CLK_4TAP  = pof_pkg::LINE_CLK_4TAP,
  parameter int LINE_CLK_8TAP  = pof_pkg::LINE_CLK_8TAP,
  parameter int LINE_CLK_10TAP = pof_pkg::LINE_CLK_10TAP
) (
  // core clock and reset
  input  wire logic                                       core_clk,
  input  wire logic                                       sys_rst,
  // configuration
  input  wire logic                                       cfg_digitize_12,
  input  wire logic [1:0]                                 cfg_out_width,
  input  wire logic [2:0]                                 cfg_tap_mode,
  // sensor readout
  input  wire logic [pof_pkg::PIX_W-1:0]                  sen_data,
  input  wire logic                                       sen_valid,
  input  wire logic                                       sen_line_end,
  input  wire logic                                       sen_frame_start,
  input  wire logic                                       sen_frame_end,
  output logic                                            sen_ready,
  output logic                                            sen_line_go,
  // video link
  input  wire logic                                       link_clk,
  output logic [pof_pkg::TAP_MAX*pof_pkg::PIX_W-1:0]      link_data,
  output logic                                            link_dval,
  output logic                                            link_lval,
  output logic                                            link_fval
);

  // ==========================================================
  // line period table, cut to counter width
  localparam logic [pof_pkg::LINE_CNT_W-1:0] MIN_1  = pof_pkg::LINE_CNT_W'(LINE_CLK_1TAP);
  localparam logic [pof_pkg::LINE_CNT_W-1:0] MIN_2  = pof_pkg::LINE_CNT_W'(LINE_CLK_2TAP);
  localparam logic [pof_pkg::LINE_CNT_W-1:0] MIN_4  = pof_pkg::LINE_CNT_W'(LINE_CLK_4TAP);
  localparam logic [pof_pkg::LINE_CNT_W-1:0] MIN_8  = pof_pkg::LINE_CNT_W'(LINE_CLK_8TAP);
  localparam logic [pof_pkg::LINE_CNT_W-1:0] MIN_10 = pof_pkg::LINE_CNT_W'(LINE_CLK_10TAP);

  // ==========================================================
  // state
  typedef struct packed {
    pof_pkg::line_state_t                       st;
    logic [pof_pkg::LINE_CNT_W-1:0]             cnt;
    logic [pof_pkg::LINE_CNT_W-1:0]             min_cnt;
    logic                                       dig12;
    logic [1:0]                                 width;
    logic [pof_pkg::TAP_CNT_W-1:0]              ntaps;
    logic [pof_pkg::TAP_MAX*pof_pkg::PIX_W-1:0] slots;
    logic [pof_pkg::TAP_CNT_W-1:0]              idx;
    logic                                       full;
    pof_pkg::grp_flags_t                        gflags;
    logic [pof_pkg::TAP_MAX*pof_pkg::PIX_W-1:0] xdata;
    pof_pkg::grp_flags_t                        xflags;
    logic                                       req;
    logic                                       ack_s1;
    logic                                       ack_s2;
    logic                                       busy;
  } core_state_t;

  localparam core_state_t CORE_RST = '{
    st:      pof_pkg::LS_WAIT,
    cnt:     pof_pkg::LINE_CNT_RST,
    min_cnt: MIN_1,
    dig12:   1'b1,
    width:   pof_pkg::OUT_12,
    ntaps:   pof_pkg::NTAPS_RST,
    default: '0
  };

  core_state_t r;
  core_state_t next_r;
  logic        take;

  pof_xfer_if xfer ();

  // ==========================================================
  // pixel mapping
  function automatic logic [pof_pkg::PIX_W-1:0] fmt_pixel(
    input logic [pof_pkg::PIX_W-1:0] raw,
    input logic                      dig12,
    input logic [1:0]                width
  );
    logic [pof_pkg::PIX_W-1:0] res;
    res = 12'h000;
    if (dig12) begin
      case (width)
        pof_pkg::OUT_10: res = {2'h0, raw[11:2]};
        pof_pkg::OUT_8:  res = {4'h0, raw[11:4]};
        default:         res = raw;
      endcase
    end else begin
      case (width)
        pof_pkg::OUT_10: res = {2'h0, raw[9:0]};
        pof_pkg::OUT_8:  res = {4'h0, raw[9:2]};
        default:         res = {raw[9:0], 2'h0};
      endcase
    end
    return res;
  endfunction

  // ==========================================================
  // line period for a tap mode
  function automatic logic [pof_pkg::LINE_CNT_W-1:0] min_line(input logic [2:0] mode);
    case (mode)
      pof_pkg::TAPS_2:  min_line = MIN_2;
      pof_pkg::TAPS_4:  min_line = MIN_4;
      pof_pkg::TAPS_8:  min_line = MIN_8;
      pof_pkg::TAPS_10: min_line = MIN_10;
      default:          min_line = MIN_1;
    endcase
  endfunction

  // ==========================================================
  // handshake toward the sensor
  assign sen_ready   = (r.st == pof_pkg::LS_RUN) && (!r.full || !r.busy);
  assign take        = sen_ready && sen_valid;
  assign sen_line_go = (r.st == pof_pkg::LS_GO);

  // ==========================================================
  // next state
  always_comb begin
    next_r        = r;
    next_r.ack_s1 = xfer.ack;
    next_r.ack_s2 = r.ack_s1;

    // cycles since the last line start, saturating
    if (r.cnt != pof_pkg::LINE_CNT_RST) begin
      next_r.cnt = r.cnt + 14'h0001;
    end

    // group accepted by link side
    if (r.busy && (r.ack_s2 == r.req)) begin
      next_r.busy = 1'b0;
    end

    // hand a full group to the link side
    if (r.full && !r.busy) begin
      next_r.xdata  = r.slots;
      next_r.xflags = r.gflags;
      next_r.req    = ~r.req;
      next_r.busy   = 1'b1;
      next_r.full   = 1'b0;
      next_r.slots  = '0;
      next_r.gflags = '0;
    end

    unique case (r.st)
      pof_pkg::LS_WAIT: begin
        if (r.cnt >= r.min_cnt) begin
          next_r.st = pof_pkg::LS_GO;
        end
      end
      pof_pkg::LS_GO: begin
        next_r.cnt     = 14'h0001;
        next_r.dig12   = cfg_digitize_12;
        next_r.width   = cfg_out_width;
        next_r.ntaps   = pof_pkg::tap_count(cfg_tap_mode);
        next_r.min_cnt = min_line(cfg_tap_mode);
        next_r.idx     = '0;
        next_r.gflags.line_first = 1'b1;
        next_r.st      = pof_pkg::LS_RUN;
      end
      pof_pkg::LS_RUN: begin
        if (take) begin
          next_r.slots[r.idx*pof_pkg::PIX_W +: pof_pkg::PIX_W] =
            fmt_pixel(sen_data, r.dig12, r.width);
          if (sen_frame_start) begin
            next_r.gflags.frame_first = 1'b1;
          end
          if (sen_frame_end) begin
            next_r.gflags.frame_last = 1'b1;
          end
          if ((r.idx == r.ntaps - 4'h1) || sen_line_end) begin
            next_r.full = 1'b1;
            next_r.idx  = '0;
          end else begin
            next_r.idx  = r.idx + 4'h1;
          end
          if (sen_line_end) begin
            next_r.gflags.line_last = 1'b1;
            next_r.st = pof_pkg::LS_WAIT;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // crossing to the link clock
  assign xfer.req   = r.req;
  assign xfer.data  = r.xdata;
  assign xfer.flags = r.xflags;

  pof_link_tx u_link (
    .link_clk  (link_clk),
    .sys_rst   (sys_rst),
    .xfer      (xfer.link),
    .link_data (link_data),
    .link_dval (link_dval),
    .link_lval (link_lval),
    .link_fval (link_fval)
  );

endmodule

// ===== verification/pof_monitor.sv
// port-level assertions for the pixel output formatter
`timescale 1ns/1ps
module pof_monitor #(
  parameter int LINE_CLK_1TAP  = 15200,
  parameter int LINE_CLK_2TAP  = 7625,
  parameter int LINE_CLK_4TAP  = 3810,
  parameter int LINE_CLK_8TAP  = 1910,
  parameter int LINE_CLK_10TAP = 1875
) (
  // core side
  input wire logic         core_clk,
  input wire logic         sys_rst,
  input wire logic         cfg_digitize_12,
  input wire logic [1:0]   cfg_out_width,
  input wire logic [2:0]   cfg_tap_mode,
  input wire logic [11:0]  sen_data,
  input wire logic         sen_valid,
  input wire logic         sen_line_end,
  input wire logic         sen_frame_start,
  input wire logic         sen_frame_end,
  input wire logic         sen_ready,
  input wire logic         sen_line_go,
  // link side
  input wire logic         link_clk,
  input wire logic [119:0] link_data,
  input wire logic         link_dval,
  input wire logic         link_lval,
  input wire logic         link_fval
);
  // ==========================================================
  // cycles since the last line start, and the tap mode it took
  logic [15:0] gap;
  logic [2:0]  tap;
  int          min_gap;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap <= 16'hffff;
      tap <= 3'h0;
    end else if (sen_line_go) begin
      gap <= 16'h0001;
      tap <= cfg_tap_mode;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h0001;
    end
  end
  always_comb begin
    case (tap)
      3'h1:    min_gap = LINE_CLK_2TAP;
      3'h2:    min_gap = LINE_CLK_4TAP;
      3'h3:    min_gap = LINE_CLK_8TAP;
      3'h4:    min_gap = LINE_CLK_10TAP;
      default: min_gap = LINE_CLK_1TAP;
    endcase
  end
  sequence s_last_taken;
    sen_valid && sen_ready && sen_line_end;
  endsequence
  // ==========================================================
  // assertions
  a_line_period:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      sen_line_go |-> 32'(gap) >= min_gap) else $error("line started too early");
  a_go_pulse:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      sen_line_go |=> !sen_line_go) else $error("line start longer than one cycle");
  a_ready_after_go:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      sen_line_go |=> sen_ready) else $error("no ready after line start");
  a_stop_after_end:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      s_last_taken |=> !sen_ready || $past(sen_line_go)) else $error("ready after line end");
  a_dval_pulse:
    assert property (@(posedge link_clk) disable iff (sys_rst)
      link_dval |=> !link_dval) else $error("data valid longer than one cycle");
  a_dval_in_line:
    assert property (@(posedge link_clk) disable iff (sys_rst)
      link_dval |-> link_lval) else $error("group outside line valid");
  a_data_hold:
    assert property (@(posedge link_clk) disable iff (sys_rst)
      !link_dval |-> $stable(link_data)) else $error("link data changed without valid");
  a_lval_end:
    assert property (@(posedge link_clk) disable iff (sys_rst)
      $fell(link_lval) |-> $past(link_dval)) else $error("line valid fell late");
  a_fval_end:
    assert property (@(posedge link_clk) disable iff (sys_rst)
      $fell(link_fval) |-> $past(link_dval)) else $error("frame valid fell late");
endmodule

bind pixel_output_formatter pof_monitor #(
  .LINE_CLK_1TAP(LINE_CLK_1TAP), .LINE_CLK_2TAP(LINE_CLK_2TAP),
  .LINE_CLK_4TAP(LINE_CLK_4TAP), .LINE_CLK_8TAP(LINE_CLK_8TAP),
  .LINE_CLK_10TAP(LINE_CLK_10TAP)
) mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .cfg_digitize_12(cfg_digitize_12),
  .cfg_out_width(cfg_out_width), .cfg_tap_mode(cfg_tap_mode), .sen_data(sen_data),
  .sen_valid(sen_valid), .sen_line_end(sen_line_end), .sen_frame_start(sen_frame_start),
  .sen_frame_end(sen_frame_end), .sen_ready(sen_ready), .sen_line_go(sen_line_go),
  .link_clk(link_clk), .link_data(link_data), .link_dval(link_dval),
  .link_lval(link_lval), .link_fval(link_fval)
);

// ===== verification/pof_grabber.sv
// frame grabber model: records each pixel group, keeping the last 64, and its line and frame flags
`timescale 1ns/1ps
module pof_grabber (
  // link clock and reset
  input wire logic         link_clk,
  input wire logic         sys_rst,
  // video link
  input wire logic [119:0] link_data,
  input wire logic         link_dval,
  input wire logic         link_lval,
  input wire logic         link_fval
);
  logic [119:0] grp [0:63];
  logic [1:0]   flg [0:63];
  int           ngrp;
  always @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ngrp <= 0;
    end else if (link_dval) begin
      grp[ngrp % 64] <= link_data;
      flg[ngrp % 64] <= {link_fval, link_lval};
      ngrp <= ngrp + 1;
    end
  end
endmodule

// ===== verification/tb_pixel_output_formatter.sv
// self-checking testbench for the pixel output formatter
`timescale 1ns/1ps
module tb_pixel_output_formatter;
  // ==========================================================
  // signals
  localparam int P1 = 200, P2 = 160, P4 = 120, P8 = 100, P10 = 80;
  logic         core_clk, link_clk, sys_rst, cfg_digitize_12, sen_valid, sen_line_end;
  logic         sen_frame_start, sen_frame_end, sen_ready, sen_line_go;
  logic         link_dval, link_lval, link_fval;
  logic [1:0]   cfg_out_width;
  logic [2:0]   cfg_tap_mode;
  logic [11:0]  sen_data;
  logic [119:0] link_data;
  int           miscompares = 0, checked = 0, cyc = 0, last_go = 0, prev_go = 0;
  int           prev_per = 0;
  logic         infr = 1'b0;
  int           per [0:7] = '{P1, P2, P4, P8, P10, P1, P1, P1};

  pixel_output_formatter #(.LINE_CLK_1TAP(P1), .LINE_CLK_2TAP(P2), .LINE_CLK_4TAP(P4),
    .LINE_CLK_8TAP(P8), .LINE_CLK_10TAP(P10)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .cfg_digitize_12(cfg_digitize_12),
    .cfg_out_width(cfg_out_width), .cfg_tap_mode(cfg_tap_mode), .sen_data(sen_data),
    .sen_valid(sen_valid), .sen_line_end(sen_line_end), .sen_frame_start(sen_frame_start),
    .sen_frame_end(sen_frame_end), .sen_ready(sen_ready), .sen_line_go(sen_line_go),
    .link_clk(link_clk), .link_data(link_data), .link_dval(link_dval),
    .link_lval(link_lval), .link_fval(link_fval));
  pof_grabber grabber (.link_clk(link_clk), .sys_rst(sys_rst), .link_data(link_data),
    .link_dval(link_dval), .link_lval(link_lval), .link_fval(link_fval));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (sen_line_go) begin
      prev_go <= last_go;
      last_go <= cyc;
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [11:0] fmt(input logic [11:0] r, input logic d12,
                                       input logic [1:0] w);
    logic [11:0] v;
    v = d12 ? r : {r[9:0], 2'h0};
    case (w)
      2'h1:    fmt = {2'h0, v[11:2]};
      2'h2:    fmt = {4'h0, v[11:4]};
      default: fmt = v;
    endcase
  endfunction
  function automatic int tc(input logic [2:0] m);
    case (m)
      3'h1:    tc = 2;
      3'h2:    tc = 4;
      3'h3:    tc = 8;
      3'h4:    tc = 10;
      default: tc = 1;
    endcase
  endfunction
  function automatic logic [11:0] pv(input int i, input logic d12);
    pv = (12'ha5c + 12'(i) * 12'h3b7) & (d12 ? 12'hfff : 12'h3ff);
  endfunction
  task automatic chk(input logic [119:0] seen, input logic [119:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic line(input logic d12, input logic [1:0] w, input logic [2:0] m,
                      input int n, input logic fs, input logic fe);
    int i, t, ng, base, gap;
    logic rdy;
    logic [119:0] e;
    i = 0;
    t = tc(m);
    ng = (n + t - 1) / t;
    base = grabber.ngrp;
    cfg_digitize_12 = d12;
    cfg_out_width = w;
    cfg_tap_mode = m;
    if (fs) infr = 1'b1;
    while (i < n) begin
      sen_data = pv(i, d12);
      sen_valid = 1'b1;
      sen_line_end = (i == n - 1);
      sen_frame_start = fs && (i == 0);
      sen_frame_end = fe && (i == n - 1);
      @(negedge core_clk);
      rdy = sen_ready;
      @(posedge core_clk);
      #1;
      if (rdy === 1'b1) i++;
    end
    sen_valid = 1'b0;
    sen_line_end = 1'b0;
    sen_frame_start = 1'b0;
    sen_frame_end = 1'b0;
    gap = last_go - prev_go;
    // line period follows the earlier line's taps
    if (prev_per > 0) chk(120'(gap >= prev_per && gap <= prev_per + 8), 120'h1);
    prev_per = per[m];
    for (int k = 0; k < 400 && grabber.ngrp < base + ng; k++) @(posedge core_clk);
    chk(120'(grabber.ngrp - base), 120'(ng));
    for (int g = 0; g < ng; g++) begin
      e = '0;
      for (int k = 0; k < t && g * t + k < n; k++) begin
        e[12 * k +: 12] = fmt(pv(g * t + k, d12), d12, w);
      end
      chk(grabber.grp[(base + g) % 64], e);
      chk(120'(grabber.flg[(base + g) % 64]), 120'({infr, 1'b1}));
    end
    if (fe) infr = 1'b0;
    repeat (3) @(posedge link_clk);
    #1;
    chk(120'({link_fval, link_lval}), 120'({infr, 1'b0}));
    @(posedge core_clk);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_formats;
    for (int d = 1; d >= 0; d--)
      for (int w = 0; w < 4; w++)
        // every digitization and width pairing, short last group
        line(d[0], w[1:0], 3'h1, 3, d == 1 && w == 0, d == 0 && w == 3);
  endtask
  task automatic t_taps;
    for (int m = 0; m < 6; m++)
      // each tap mode plus one spill pixel
      line(1'b1, 2'h2, m[2:0], tc(m[2:0]) + 1, 1'b0, 1'b0);
  endtask
  task automatic t_short;
    // single pixel in a ten-tap group
    line(1'b0, 2'h1, 3'h4, 1, 1'b1, 1'b1);
  endtask

  initial begin
    sys_rst = 1'b1;
    cfg_digitize_12 = 1'b1;
    cfg_out_width = 2'h0;
    cfg_tap_mode = 3'h1;
    sen_data = 12'h000;
    sen_valid = 1'b0;
    sen_line_end = 1'b0;
    sen_frame_start = 1'b0;
    sen_frame_end = 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    chk(120'({link_dval, link_lval, link_fval, sen_ready, sen_line_go}), 120'h0);
    sys_rst = 1'b0;
    t_formats();
    t_taps();
    t_short();
    end_sim();
  end
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule
